// *** verilog/kpi_pkg.sv ***
// Purpose: shared constants and carriers for the keypad pin interrupt block
// Assumes: 32-bit Avalon-MM slave with byte addresses, one word per register
// Notes:   each unit has 8 inputs; unit control registers are 8 bits wide, interrupt status and mask 2 bits
package kpi_pkg;

  localparam int UNIT_W = 8;   // inputs per unit
  localparam int ADDR_W = 5;   // byte address width
  localparam int DATA_W = 32;  // bus data width

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_A_SC   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_A_PE   = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_A_ES   = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_B_SC   = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_B_PE   = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_B_ES   = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MK = 5'h1C;

  // status/control field positions
  localparam int SC_MODE_BIT = 0;
  localparam int SC_REQ_BIT  = 1;
  localparam int SC_ACK_BIT  = 2;
  localparam int SC_FLAG_BIT = 3;

  // interrupt status/mask field positions
  localparam int IRQ_A_BIT = 0;
  localparam int IRQ_B_BIT = 1;
  localparam int IRQ_W     = 2;

  // reset values
  localparam logic [UNIT_W-1:0] RST_PE   = 8'h00;
  localparam logic [UNIT_W-1:0] RST_ES   = 8'h00;
  localparam logic [IRQ_W-1:0]  RST_IRQ  = 2'h0;
  localparam logic [DATA_W-1:0] RST_RDAT = 32'h0000_0000;

  // software control bits of one status/control register
  typedef struct packed {
    logic req_en;      // request_enable
    logic level_mode;  // level_detect_mode
  } kpi_sc_t;

  // pull device controls for one unit
  typedef struct packed {
    logic [UNIT_W-1:0] up;
    logic [UNIT_W-1:0] down;
  } kpi_pull_t;

endpackage

// *** verilog/kpi_sync.sv ***
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: inputs are quasi-static levels from port pins
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module kpi_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] stab_ff;
  logic [WIDTH-1:0] nxt_stab;

  // next values of both stages
  always_comb begin
    nxt_meta = async_in;
    nxt_stab = meta_ff;
  end

  // register both stages
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_ff <= '0;
      stab_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      stab_ff <= nxt_stab;
    end
  end

  assign sync_out = stab_ff;
endmodule // kpi_sync

// *** verilog/kpi_unit.sv ***
// Purpose: one eight-input keypad detector with its pending flag
// Assumes: pins_in are already synchronised to clk_in
// Notes:   a detection in the ack cycle keeps the flag set
`timescale 1ns/1ps
module kpi_unit
  import kpi_pkg::*;
#(
  parameter int WIDTH = UNIT_W
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] pins_in,
  input  wire logic [WIDTH-1:0] pin_en_in,
  input  wire logic [WIDTH-1:0] polarity_in,
  input  wire logic             level_mode_in,
  input  wire logic             ack_in,
  output logic                  flag_out,
  output logic                  set_out
);
  logic [WIDTH-1:0] act;
  logic [WIDTH-1:0] prev_ff;
  logic [WIDTH-1:0] nxt_prev;
  logic             flag_ff;
  logic             nxt_flag;
  logic             edge_hit;
  logic             level_hit;
  logic             trig;

  // detection and flag next state
  always_comb begin
    act       = ~(pins_in ^ polarity_in);               // [RQ8]
    nxt_prev  = act;                                    // [RQ15]
    edge_hit  = |(pin_en_in & act & ~prev_ff);          // [RQ15] [RQ7]
    level_hit = level_mode_in & (|(pin_en_in & act));   // [RQ6]
    trig      = edge_hit | level_hit;                   // [RQ6]
    // set beats acknowledge; level hold blocks the clear
    if (trig) begin
      nxt_flag = 1'b1;                                  // [RQ3] [RQ14]
    end else if (ack_in) begin
      nxt_flag = 1'b0;                                  // [RQ4]
    end else begin
      nxt_flag = flag_ff;
    end
  end

  // register sample history and flag
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prev_ff <= '0;
      flag_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
      flag_ff <= nxt_flag;
    end
  end

  assign flag_out = flag_ff;
  assign set_out  = trig & ~flag_ff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_edge_sets;
    |(pin_en_in & act & ~prev_ff) |=> flag_ff;
  endproperty
  a_edge_sets: assert property (p_edge_sets) // [RQ6]
    else $error("enabled active edge did not set flag");

  property p_flag_holds;
    flag_ff && !ack_in |=> flag_ff;
  endproperty
  a_flag_holds: assert property (p_flag_holds) // [RQ3]
    else $error("flag dropped without acknowledge");

  property p_level_blocks_ack;
    level_mode_in && |(pin_en_in & act) |=> flag_ff;
  endproperty
  a_level_blocks_ack: assert property (p_level_blocks_ack) // [RQ14]
    else $error("acknowledge cleared flag while level active");

  property p_disabled_ignored;
    !flag_ff && pin_en_in == '0 |=> !flag_ff;
  endproperty
  a_disabled_ignored: assert property (p_disabled_ignored) // [RQ7]
    else $error("flag set with no input enabled");

  property p_ack_clears;
    flag_ff && ack_in && !level_mode_in && !edge_hit |=> !flag_ff;
  endproperty
  a_ack_clears: assert property (p_ack_clears) // [RQ4]
    else $error("acknowledge failed to clear flag");

  property p_edge_needs_history;
    !flag_ff && !level_mode_in ##1 !ack_in && flag_ff
      |-> $past(edge_hit);
  endproperty
  a_edge_needs_history: assert property (p_edge_needs_history) // [RQ15]
    else $error("edge-mode flag set without a sampled edge");

  c_level_retrigger: cover property (
    level_mode_in && flag_ff && ack_in ##1 flag_ff);
endmodule // kpi_unit

// *** verilog/kpi_top.sv ***
// Purpose: two keypad pin interrupt units behind an Avalon-MM slave
// Assumes: port pins asynchronous; pull enables come from port logic
// Notes:   waitrequest drops for one cycle one cycle after a request
// Operation
// RQ1 - unit a inputs 0-3 from port a bits 0-3, 4-7 from port b 0-3
// RQ2 - unit b input n comes from port d bit n
// RQ3 - status bit 3 is a read-only pending flag set on detection
// RQ4 - writing 1 to status bit 2 acknowledges; bit 2 reads as 0
// RQ5 - status bit 1 gates the request; request follows the pending flag
// RQ6 - status bit 0: 0 edges only, 1 edges plus persisting levels
// RQ7 - pin enable bits select which inputs are watched
// RQ8 - polarity 0 detects falling/low, 1 detects rising/high
// RQ9 - polarity also picks pull-up at 0 and pull-down at 1
// RQ10 - unit a status/control matches unit b in bits and behaviour
// RQ11 - software writes zero to reserved status bits 7 to 4
// RQ12 - unit b has its own polarity register with the same dual role
// RQ13 - pin pull enable switches the pull; polarity picks up or down
// RQ14 - in level mode acknowledge fails while an input stays active
// RQ15 - inputs are registered; edges come from current versus previous
`timescale 1ns/1ps
module kpi_top
  import kpi_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [DATA_W-1:0] avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [DATA_W-1:0] avs_readdata_out,
  output logic                   avs_waitrequest_out,
  input  wire logic [3:0]        port_a_in,
  input  wire logic [3:0]        port_b_in,
  input  wire logic [7:0]        port_d_in,
  input  wire logic [UNIT_W-1:0] pull_en_a_in,
  input  wire logic [UNIT_W-1:0] pull_en_b_in,
  output kpi_pkg::kpi_pull_t     pull_a_out,
  output kpi_pkg::kpi_pull_t     pull_b_out,
  output logic                   request_a_out,
  output logic                   request_b_out,
  output logic                   irq_out
);
  import kpi_pkg::*;

  logic [3:0]        a_sync;
  logic [3:0]        b_sync;
  logic [7:0]        d_sync;
  logic [UNIT_W-1:0] pins_a;
  logic [UNIT_W-1:0] pins_b;

  kpi_sc_t           sc_a_ff;
  kpi_sc_t           nxt_sc_a;
  kpi_sc_t           sc_b_ff;
  kpi_sc_t           nxt_sc_b;
  logic [UNIT_W-1:0] pe_a_ff;
  logic [UNIT_W-1:0] nxt_pe_a;
  logic [UNIT_W-1:0] es_a_ff;
  logic [UNIT_W-1:0] nxt_es_a;
  logic [UNIT_W-1:0] pe_b_ff;
  logic [UNIT_W-1:0] nxt_pe_b;
  logic [UNIT_W-1:0] es_b_ff;
  logic [UNIT_W-1:0] nxt_es_b;
  logic [IRQ_W-1:0]  ist_ff;
  logic [IRQ_W-1:0]  nxt_ist;
  logic [IRQ_W-1:0]  imk_ff;
  logic [IRQ_W-1:0]  nxt_imk;
  logic [DATA_W-1:0] rdat_ff;
  logic [DATA_W-1:0] nxt_rdat;
  logic              wait_ff;
  logic              nxt_wait;

  logic              take;
  logic              wen;
  logic [UNIT_W-1:0] wbyte;
  logic              ack_a;
  logic              ack_b;
  logic              flag_a;
  logic              flag_b;
  logic              set_a;
  logic              set_b;

  // pin synchronisers, one per port group
  kpi_sync #(.WIDTH(4)) u_sync_a (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (port_a_in),
    .sync_out (a_sync)
  );
  kpi_sync #(.WIDTH(4)) u_sync_b (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (port_b_in),
    .sync_out (b_sync)
  );
  kpi_sync #(.WIDTH(8)) u_sync_d (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (port_d_in),
    .sync_out (d_sync)
  );

  // pin to unit input mapping
  assign pins_a = {b_sync, a_sync};  // [RQ1]
  assign pins_b = d_sync;            // [RQ2]

  // the two detector units share one design
  kpi_unit u_unit_a (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .pins_in       (pins_a),
    .pin_en_in     (pe_a_ff),
    .polarity_in   (es_a_ff),
    .level_mode_in (sc_a_ff.level_mode),
    .ack_in        (ack_a),
    .flag_out      (flag_a),
    .set_out       (set_a)
  );                                  // [RQ10]
  kpi_unit u_unit_b (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .pins_in       (pins_b),
    .pin_en_in     (pe_b_ff),
    .polarity_in   (es_b_ff),
    .level_mode_in (sc_b_ff.level_mode),
    .ack_in        (ack_b),
    .flag_out      (flag_b),
    .set_out       (set_b)
  );                                  // [RQ12]

  // bus strobes: take starts, wen commits on the low-wait edge
  always_comb begin
    take  = (avs_read_in | avs_write_in) & wait_ff;
    wen   = avs_write_in & ~wait_ff & avs_byteenable_in[0];
    wbyte = avs_writedata_in[UNIT_W-1:0];
    ack_a = wen && avs_address_in == OFS_A_SC
            && wbyte[SC_ACK_BIT];              // [RQ4]
    ack_b = wen && avs_address_in == OFS_B_SC
            && wbyte[SC_ACK_BIT];              // [RQ4]
  end

  // register writes; flag bit is never written
  always_comb begin
    nxt_sc_a = sc_a_ff;
    nxt_sc_b = sc_b_ff;
    nxt_pe_a = pe_a_ff;
    nxt_es_a = es_a_ff;
    nxt_pe_b = pe_b_ff;
    nxt_es_b = es_b_ff;
    nxt_imk  = imk_ff;
    if (wen) begin
      case (avs_address_in)
        OFS_A_SC: begin
          nxt_sc_a.req_en     = wbyte[SC_REQ_BIT];   // [RQ5]
          nxt_sc_a.level_mode = wbyte[SC_MODE_BIT];  // [RQ6]
        end
        OFS_B_SC: begin
          nxt_sc_b.req_en     = wbyte[SC_REQ_BIT];   // [RQ5]
          nxt_sc_b.level_mode = wbyte[SC_MODE_BIT];  // [RQ6]
        end
        OFS_A_PE:   nxt_pe_a = wbyte;                // [RQ7]
        OFS_A_ES:   nxt_es_a = wbyte;                // [RQ8]
        OFS_B_PE:   nxt_pe_b = wbyte;                // [RQ7]
        OFS_B_ES:   nxt_es_b = wbyte;                // [RQ12]
        OFS_IRQ_MK: nxt_imk  = wbyte[IRQ_W-1:0];
        default:    nxt_imk  = imk_ff;
      endcase
    end
  end

  // sticky event bits, set wins over write-one-to-clear
  always_comb begin
    nxt_ist = ist_ff;
    if (wen && avs_address_in == OFS_IRQ_ST) begin
      nxt_ist = ist_ff & ~wbyte[IRQ_W-1:0];
    end
    nxt_ist[IRQ_A_BIT] = nxt_ist[IRQ_A_BIT] | set_a;
    nxt_ist[IRQ_B_BIT] = nxt_ist[IRQ_B_BIT] | set_b;
  end

  // read mux and one-cycle waitrequest drop
  always_comb begin
    nxt_wait = ~take;
    nxt_rdat = rdat_ff;
    if (take && avs_read_in) begin
      nxt_rdat = RST_RDAT;
      case (avs_address_in)
        OFS_A_SC: begin
          nxt_rdat[SC_FLAG_BIT] = flag_a;            // [RQ3]
          nxt_rdat[SC_REQ_BIT]  = sc_a_ff.req_en;
          nxt_rdat[SC_MODE_BIT] = sc_a_ff.level_mode;
        end                                          // [RQ4] [RQ10]
        OFS_B_SC: begin
          nxt_rdat[SC_FLAG_BIT] = flag_b;            // [RQ3]
          nxt_rdat[SC_REQ_BIT]  = sc_b_ff.req_en;
          nxt_rdat[SC_MODE_BIT] = sc_b_ff.level_mode;
        end                                          // [RQ4]
        OFS_A_PE:   nxt_rdat[UNIT_W-1:0] = pe_a_ff;
        OFS_A_ES:   nxt_rdat[UNIT_W-1:0] = es_a_ff;
        OFS_B_PE:   nxt_rdat[UNIT_W-1:0] = pe_b_ff;
        OFS_B_ES:   nxt_rdat[UNIT_W-1:0] = es_b_ff;
        OFS_IRQ_ST: nxt_rdat[IRQ_W-1:0]  = ist_ff;
        OFS_IRQ_MK: nxt_rdat[IRQ_W-1:0]  = imk_ff;
        default:    nxt_rdat = RST_RDAT;             // unmapped reads 0
      endcase
    end
  end

  // register file and bus state
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sc_a_ff <= '0;
      sc_b_ff <= '0;
      pe_a_ff <= RST_PE;
      es_a_ff <= RST_ES;
      pe_b_ff <= RST_PE;
      es_b_ff <= RST_ES;
      ist_ff  <= RST_IRQ;
      imk_ff  <= RST_IRQ;
      rdat_ff <= RST_RDAT;
      wait_ff <= 1'b1;
    end else begin
      sc_a_ff <= nxt_sc_a;
      sc_b_ff <= nxt_sc_b;
      pe_a_ff <= nxt_pe_a;
      es_a_ff <= nxt_es_a;
      pe_b_ff <= nxt_pe_b;
      es_b_ff <= nxt_es_b;
      ist_ff  <= nxt_ist;
      imk_ff  <= nxt_imk;
      rdat_ff <= nxt_rdat;
      wait_ff <= nxt_wait;
    end
  end

  // registered outputs: requests, interrupt and pull controls
  logic      req_a_ff;
  logic      nxt_req_a;
  logic      req_b_ff;
  logic      nxt_req_b;
  logic      irq_ff;
  logic      nxt_irq;
  kpi_pull_t pull_a_ff;
  kpi_pull_t nxt_pull_a;
  kpi_pull_t pull_b_ff;
  kpi_pull_t nxt_pull_b;

  always_comb begin
    nxt_req_a       = flag_a & sc_a_ff.req_en;       // [RQ5]
    nxt_req_b       = flag_b & sc_b_ff.req_en;       // [RQ5]
    nxt_irq         = |(ist_ff & imk_ff);
    nxt_pull_a.up   = pull_en_a_in & ~es_a_ff;       // [RQ9] [RQ13]
    nxt_pull_a.down = pull_en_a_in & es_a_ff;        // [RQ9] [RQ13]
    nxt_pull_b.up   = pull_en_b_in & ~es_b_ff;       // [RQ12] [RQ13]
    nxt_pull_b.down = pull_en_b_in & es_b_ff;        // [RQ12] [RQ13]
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      req_a_ff  <= 1'b0;
      req_b_ff  <= 1'b0;
      irq_ff    <= 1'b0;
      pull_a_ff <= '0;
      pull_b_ff <= '0;
    end else begin
      req_a_ff  <= nxt_req_a;
      req_b_ff  <= nxt_req_b;
      irq_ff    <= nxt_irq;
      pull_a_ff <= nxt_pull_a;
      pull_b_ff <= nxt_pull_b;
    end
  end

  assign avs_readdata_out    = rdat_ff;
  assign avs_waitrequest_out = wait_ff;
  assign request_a_out       = req_a_ff;
  assign request_b_out       = req_b_ff;
  assign irq_out             = irq_ff;
  assign pull_a_out          = pull_a_ff;
  assign pull_b_out          = pull_b_ff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_req_gate;
    !sc_a_ff.req_en ##1 !sc_a_ff.req_en |-> !request_a_out;
  endproperty
  a_req_gate: assert property (p_req_gate) // [RQ5]
    else $error("request raised while disabled");

  property p_req_follows;
    flag_b && sc_b_ff.req_en |=> request_b_out;
  endproperty
  a_req_follows: assert property (p_req_follows) // [RQ5]
    else $error("request missing with flag and enable set");

  property p_ack_reads_zero;
    take && avs_read_in && (avs_address_in == OFS_A_SC
      || avs_address_in == OFS_B_SC) |=> !avs_readdata_out[SC_ACK_BIT]
      && avs_readdata_out[7:4] == 4'h0;
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) // [RQ4]
    else $error("acknowledge or reserved bit read back nonzero");

  property p_pull_select;
    1'b1 |=> pull_a_out.down == ($past(pull_en_a_in) & $past(es_a_ff))
      && pull_a_out.up == ($past(pull_en_a_in) & ~$past(es_a_ff));
  endproperty
  a_pull_select: assert property (p_pull_select) // [RQ9]
    else $error("pull device does not follow polarity");

  property p_wait_answer;
    (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
  endproperty
  a_wait_answer: assert property (p_wait_answer)
    else $error("waitrequest did not drop for exactly one cycle");

  property p_map_a;
    1'b1 |-> pins_a[7:4] == b_sync && pins_a[3:0] == a_sync;
  endproperty
  a_map_a: assert property (p_map_a) // [RQ1]
    else $error("unit a input mapping wrong");

  property p_irq_sticky;
    ist_ff[IRQ_A_BIT] && !(wen && avs_address_in == OFS_IRQ_ST)
      |=> ist_ff[IRQ_A_BIT];
  endproperty
  a_irq_sticky: assert property (p_irq_sticky)
    else $error("event bit cleared without write");

  c_read_sc: cover property (take && avs_read_in
    && avs_address_in == OFS_A_SC ##1 avs_readdata_out[SC_FLAG_BIT]);
  c_ack_clear: cover property (flag_b ##1 ack_b ##1 !flag_b);
  c_irq: cover property (!irq_out ##1 irq_out);
endmodule // kpi_top

// *** dv/kpi_keys.sv ***
// Purpose: keys or switches sitting on the keypad port pins
// Assumes: a closed key forces its level; an open pin rests on its pull
// Notes:   an open pin with no pull toggles every cycle, like a floating line
`timescale 1ns/1ps
module kpi_keys
  import kpi_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic [15:0]  closed_in,
  input  wire logic [15:0]  level_in,
  input  kpi_pkg::kpi_pull_t pull_a_in,
  input  kpi_pkg::kpi_pull_t pull_b_in,
  output logic      [3:0]   port_a_out,
  output logic      [3:0]   port_b_out,
  output logic      [7:0]   port_d_out
);
  logic [15:0] up;
  logic [15:0] dn;
  logic [15:0] pin;
  logic        float_ff = 1'b0;

  // floating pattern, so an unpulled pin never looks stable
  always_ff @(posedge clk_in) begin
    float_ff <= ~float_ff;
  end

  // pull devices seen by each pin, unit a low, unit b high
  assign up = {pull_b_in.up, pull_a_in.up};
  assign dn = {pull_b_in.down, pull_a_in.down};

  // closed key wins, then the pull, then the floating pattern
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (closed_in[i]) pin[i] = level_in[i];
      else if (up[i]) pin[i] = 1'b1;
      else if (dn[i]) pin[i] = 1'b0;
      else pin[i] = float_ff;
    end
  end

  // board wiring of the keys onto the ports
  assign port_a_out = pin[3:0];
  assign port_b_out = pin[7:4];
  assign port_d_out = pin[15:8];
endmodule // kpi_keys

// *** dv/keypad_pin_interrupt_tb_top.sv ***
// Purpose: self-checking bench for the keypad pin interrupt block
// Assumes: one-cycle waitrequest answer; keys model drives the pins
// Notes:   read results checked by a monitor against a queue of notes
`timescale 1ns/1ps
module keypad_pin_interrupt_tb_top;
  import kpi_pkg::*;
  localparam logic W = 1'b1;
  localparam logic R = 1'b0;
  logic              clk_in = 1'b0;
  logic              reset_in = 1'b1;
  logic [ADDR_W-1:0] adr = '0;
  logic              rd = 1'b0;
  logic              wr = 1'b0;
  logic [DATA_W-1:0] wdat = '0;
  logic [3:0]        ben = 4'hF;
  logic [DATA_W-1:0] rdat;
  logic              wreq;
  logic [3:0]        pa;
  logic [3:0]        pb;
  logic [7:0]        pd;
  logic [7:0]        pen_a = '0;
  logic [7:0]        pen_b = '0;
  kpi_pull_t         pl_a;
  kpi_pull_t         pl_b;
  logic              req_a;
  logic              req_b;
  logic              irq;
  logic [15:0]       closed = '0;
  logic [15:0]       level = '0;
  logic [31:0]       exp_q[$];
  int                fails = 0;
  int                compares = 0;

  always #5 clk_in = ~clk_in;

  kpi_top dut (.clk_in(clk_in), .reset_in(reset_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_byteenable_in(ben),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .port_a_in(pa), .port_b_in(pb), .port_d_in(pd),
    .pull_en_a_in(pen_a), .pull_en_b_in(pen_b),
    .pull_a_out(pl_a), .pull_b_out(pl_b), .request_a_out(req_a),
    .request_b_out(req_b), .irq_out(irq));

  kpi_keys keys (.clk_in(clk_in), .closed_in(closed), .level_in(level),
    .pull_a_in(pl_a), .pull_b_in(pl_b), .port_a_out(pa),
    .port_b_out(pb), .port_d_out(pd));

  // comparison of bus read data
  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // comparison of pin and request outputs
  task automatic cmp_pin(input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // one bus cycle; a read notes its expected data first
  // the wait has no limit of its own: the watchdog ends a hang
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [7:0] d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {24'h00_0000, d};
    if (!w) exp_q.push_back({24'h00_0000, d});
    do begin
      @(posedge clk_in);
    end while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
    tick(3);
  endtask

  // press or release key k; a pressed key shows the active level
  task automatic key(input int k, input logic p);
    closed[k] <= p;
    level[k] <= k[0];
  endtask

  // monitor: takes the oldest note when read data is handed over
  always @(posedge clk_in) begin
    if (rd && wreq === 1'b0) begin
      if (exp_q.size() == 0) fails++;
      else cmp_rd(exp_q.pop_front(), rdat);
    end
  end

  task automatic tally_and_finish();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #500_000;
    fails++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    logic [ADDR_W-1:0] sc;
    logic [ADDR_W-1:0] pe;
    logic [ADDR_W-1:0] es;
    logic [7:0]        m;
    logic [7:0]        ra;
    logic [7:0]        rb;
    void'($urandom(32'hd5364c72));
    tick(12);
    reset_in <= 1'b0;
    tick(1);
    // reset values of every register
    for (int i = 0; i < 8; i++) bus(R, ADDR_W'(i * 4), 8'h00);
    // enable and polarity read back, pulls follow polarity and the pull enables
    for (int u = 0; u < 2; u++) begin
      pe = u ? OFS_B_PE : OFS_A_PE;
      es = u ? OFS_B_ES : OFS_A_ES;
      ra = 8'($urandom());
      rb = 8'($urandom());
      pen_a <= 8'($urandom());
      pen_b <= 8'($urandom());
      bus(W, pe, ra);
      bus(W, es, rb);
      bus(R, pe, ra);
      bus(R, es, rb);
      if (u == 0) cmp_pin({pen_a & ~rb, pen_a & rb}, pl_a);
      else cmp_pin({pen_b & ~rb, pen_b & rb}, pl_b);
      ben <= 4'hE;
      bus(W, pe, ~ra);
      ben <= 4'hF;
      bus(R, pe, ra);
    end
    pen_a <= 8'hFF;
    pen_b <= 8'hFF;
    // every input of both units, odd inputs active high
    for (int u = 0; u < 2; u++) begin
      sc = u ? OFS_B_SC : OFS_A_SC;
      pe = u ? OFS_B_PE : OFS_A_PE;
      es = u ? OFS_B_ES : OFS_A_ES;
      bus(W, pe, 8'h00);
      bus(W, es, 8'hAA);
      tick(8);
      bus(W, sc, 8'h04);
      bus(R, sc, 8'h00);
      for (int i = 0; i < 8; i++) begin
        m = 8'h01 << i;
        bus(W, pe, ~m);
        key(u * 8 + i, 1'b1);
        tick(8);
        bus(R, sc, 8'h00);
        bus(W, pe, m);
        tick(8);
        bus(R, sc, 8'h00);
        key(u * 8 + i, 1'b0);
        tick(8);
        key(u * 8 + i, 1'b1);
        tick(8);
        bus(R, sc, 8'h08);
        bus(W, sc, 8'h0A);
        cmp_pin({14'h0, u == 1, u == 0}, {14'h0, req_b, req_a});
        bus(W, sc, 8'h00);
        cmp_pin(16'h0000, {14'h0, req_b, req_a});
        bus(R, sc, 8'h08);
        bus(W, sc, 8'h04);
        bus(R, sc, 8'h00);
        key(u * 8 + i, 1'b0);
        tick(8);
        bus(R, sc, 8'h00);
      end
    end
    // level mode on input 0 of each unit, pressed before it is enabled
    for (int u = 0; u < 2; u++) begin
      sc = u ? OFS_B_SC : OFS_A_SC;
      pe = u ? OFS_B_PE : OFS_A_PE;
      bus(W, sc, 8'h01);
      key(u * 8, 1'b1);
      tick(8);
      bus(W, pe, 8'h01);
      tick(8);
      bus(R, sc, 8'h09);
      bus(W, sc, 8'h05);
      bus(R, sc, 8'h09);
      key(u * 8, 1'b0);
      tick(8);
      bus(W, sc, 8'h05);
      bus(R, sc, 8'h01);
    end
    // event status, mask and interrupt line
    bus(R, OFS_IRQ_ST, 8'h03);
    cmp_pin(16'h0000, {15'h0, irq});
    bus(W, OFS_IRQ_MK, 8'h02);
    cmp_pin(16'h0001, {15'h0, irq});
    bus(W, OFS_IRQ_ST, 8'h02);
    cmp_pin(16'h0000, {15'h0, irq});
    bus(R, OFS_IRQ_ST, 8'h01);
    bus(W, OFS_IRQ_MK, 8'h03);
    cmp_pin(16'h0001, {15'h0, irq});
    bus(W, OFS_IRQ_ST, 8'h01);
    cmp_pin(16'h0000, {15'h0, irq});
    bus(R, OFS_IRQ_ST, 8'h00);
    bus(R, OFS_IRQ_MK, 8'h03);
    tally_and_finish();
  end
endmodule // keypad_pin_interrupt_tb_top
